// ===== rail_override_regs.sv
// Purpose: override / output level register and first fault mask register,
//          with the rail enable, general output and shutdown logic they steer
// Assumes: the I2C slave front end presents one-cycle read/write strobes;
//          factory configuration and the disable register are inputs
// Notes:   all outputs are registered, so input changes land one clock later and register writes two clocks later
//
// Notes on behaviour
// - out 4 in I2C open-drain mode follows level bit 7, low or released.
// - outs 3..1 in I2C mode follow level bits 6..4, open-drain or push-pull.
// - outs not in I2C mode follow their power-good tree; level bit ignored.
// - bit 3 forces termination LDO on unless its permit bit is 0.
// - bit 2 forces the factory-selected switch B2 or LDO A1 on unless permit 0.
// - bit 1 forces load switch B1 on unless its permit bit is 0.
// - bit 0 forces LDO A3 on unless its permit bit is 0.
// - mask bits 0..5 at 1 stop buck rail 1..6 faults causing shutdown.
// - mask bits 7 and 6 do the same for LDO A2 and switch A1.
// - a permit bit at 0 holds its rail off whatever the control pins say.
module rail_override_regs (
  input  wire logic        clk,
  input  wire logic        arst_n,
  // register port from the I2C slave front end
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // factory configuration
  input  wire logic [3:0]  out_i2c_mode,
  input  wire logic [3:0]  out_push_pull,
  input  wire logic        shared_sel_ldo,
  // permit bits held in the disable register
  input  wire logic        term_ldo_permit,
  input  wire logic        shared_rail_permit,
  input  wire logic        switch_b1_permit,
  input  wire logic        ldo_a3_permit,
  // pin or power-good enable requests: term, shared, b1, a3
  input  wire logic [3:0]  rail_req,
  input  wire logic [3:0]  pg_tree,
  input  wire logic [7:0]  rail_fault,
  // outputs
  output logic      [4:0]  rail_en,
  output logic      [3:0]  gp_out_o,
  output logic      [3:0]  gp_out_oe,
  output logic             shutdown_req
);

  // ==========================================================================
  // register file
  logic [7:0] ovr_q;
  logic [7:0] ovr_d;
  logic [7:0] fmask_q;
  logic [7:0] fmask_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;

  always_comb begin
    ovr_d    = ovr_q;
    fmask_d  = fmask_q;
    rdata_d  = rdata_q;
    rvalid_d = reg_rd;
    if (reg_wr && reg_addr == rail_override_pkg::OVR_ADDR) begin
      ovr_d = reg_wdata;
    end
    if (reg_wr && reg_addr == rail_override_pkg::FMASK_ADDR) begin
      fmask_d = reg_wdata;
    end
    if (reg_rd) begin
      // unmapped offsets read as zero so the host sees a defined value
      unique case (reg_addr)
        rail_override_pkg::OVR_ADDR:   rdata_d = ovr_q;
        rail_override_pkg::FMASK_ADDR: rdata_d = fmask_q;
        default:                       rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ovr_q    <= rail_override_pkg::OVR_RESET;
      fmask_q  <= rail_override_pkg::FMASK_RESET;
      rdata_q  <= rail_override_pkg::RDATA_RESET;
      rvalid_q <= 1'b0;
    end else begin
      ovr_q    <= ovr_d;
      fmask_q  <= fmask_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  // ==========================================================================
  // rail enables
  function automatic logic rail_on(input logic permit, input logic ovr, input logic req);
    rail_on = permit & (ovr | req);
  endfunction

  logic [4:0] en_q;
  logic [4:0] en_d;
  logic       shared_on;

  always_comb begin
    shared_on = rail_on(shared_rail_permit, ovr_q[rail_override_pkg::SHARED_RAIL_BIT],
                        rail_req[1]);
    en_d = '0;
    en_d[rail_override_pkg::EN_TERM_LDO] = rail_on(term_ldo_permit,
        ovr_q[rail_override_pkg::TERM_LDO_BIT], rail_req[0]);
    // the one override bit drives only the rail the factory fitted
    en_d[rail_override_pkg::EN_SWITCH_B2] = shared_on & ~shared_sel_ldo;
    en_d[rail_override_pkg::EN_LDO_A1]    = shared_on & shared_sel_ldo;
    en_d[rail_override_pkg::EN_SWITCH_B1] = rail_on(switch_b1_permit,
        ovr_q[rail_override_pkg::SWITCH_B1_BIT], rail_req[2]);
    en_d[rail_override_pkg::EN_LDO_A3] = rail_on(ldo_a3_permit,
        ovr_q[rail_override_pkg::LDO_A3_BIT], rail_req[3]);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q <= '0;
    end else begin
      en_q <= en_d;
    end
  end

  assign rail_en = en_q;

  // ==========================================================================
  // general purpose outputs
  logic [3:0] gp_o_q;
  logic [3:0] gp_o_d;
  logic [3:0] gp_oe_q;
  logic [3:0] gp_oe_d;

  always_comb begin
    logic lvl;
    logic pp;
    lvl = 1'b0;
    pp  = 1'b0;
    gp_o_d  = '0;
    gp_oe_d = '0;
    for (int i = 0; i < rail_override_pkg::NUM_GP_OUT; i++) begin
      // out 4 has no push-pull option
      pp  = (i == rail_override_pkg::NUM_GP_OUT - 1) ? 1'b0 : out_push_pull[i];
      lvl = out_i2c_mode[i] ? ovr_q[rail_override_pkg::OUT1_LEVEL_BIT + i]
                            : pg_tree[i];
      // open-drain high releases the pin and lets the pull-up do the work
      gp_o_d[i]  = pp ? lvl : 1'b0;
      gp_oe_d[i] = pp ? 1'b1 : ~lvl;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gp_o_q  <= '0;
      gp_oe_q <= '0;
    end else begin
      gp_o_q  <= gp_o_d;
      gp_oe_q <= gp_oe_d;
    end
  end

  assign gp_out_o  = gp_o_q;
  assign gp_out_oe = gp_oe_q;

  // ==========================================================================
  // fault masking
  logic shut_q;
  logic shut_d;

  always_comb begin
    // bits 0..5 are the buck rails, 6 switch A1, 7 LDO A2 in one vector
    shut_d = |(rail_fault & ~fmask_q);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shut_q <= 1'b0;
    end else begin
      shut_q <= shut_d;
    end
  end

  assign shutdown_req = shut_q;

  // ==========================================================================
  // assertions
  a_term_enable: assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 |=> rail_en[0] == $past(term_ldo_permit & (ovr_q[3] | rail_req[0])))
    else $error("termination LDO enable wrong");

  a_shared_select: assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 |=> !(rail_en[1] && rail_en[2]) &&
      (rail_en[1] | rail_en[2]) == $past(shared_rail_permit & (ovr_q[2] | rail_req[1])))
    else $error("shared rail enable wrong");

  a_b1_enable: assert property (@(posedge clk) disable iff (!arst_n)
    (switch_b1_permit && ovr_q[1]) |=> rail_en[3])
    else $error("switch B1 not forced on");

  a_a3_enable: assert property (@(posedge clk) disable iff (!arst_n)
    (ldo_a3_permit && !ovr_q[0]) |=> rail_en[4] == $past(rail_req[3]))
    else $error("LDO A3 does not follow its request");

  a_permit_off: assert property (@(posedge clk) disable iff (!arst_n)
    !term_ldo_permit ##1 !term_ldo_permit |=> !rail_en[0] && !$past(rail_en[0]))
    else $error("rail on while not permitted");

  a_out4_level: assert property (@(posedge clk) disable iff (!arst_n)
    out_i2c_mode[3] |=> gp_out_oe[3] == !$past(ovr_q[7]) && !gp_out_o[3])
    else $error("out 4 does not follow its level bit");

  a_out_push_pull: assert property (@(posedge clk) disable iff (!arst_n)
    (out_i2c_mode[0] && out_push_pull[0]) |=> gp_out_oe[0] && gp_out_o[0] == $past(ovr_q[4]))
    else $error("out 1 push-pull level wrong");

  a_out_pg_tree: assert property (@(posedge clk) disable iff (!arst_n)
    (!out_i2c_mode[1] && !out_push_pull[1]) |=> gp_out_oe[1] == !$past(pg_tree[1]))
    else $error("out 2 does not follow its power-good tree");

  a_fault_mask: assert property (@(posedge clk) disable iff (!arst_n)
    (rail_fault[5] && !fmask_q[5]) |=> shutdown_req)
    else $error("unmasked buck fault did not shut down");

  a_fault_masked: assert property (@(posedge clk) disable iff (!arst_n)
    (rail_fault == 8'hC0 && fmask_q[7:6] == 2'h3) |=> !shutdown_req)
    else $error("masked fault caused shutdown");

  a_reg_readback: assert property (@(posedge clk) disable iff (!arst_n)
    reg_rd && reg_addr == rail_override_pkg::FMASK_ADDR |=> reg_rvalid && reg_rdata == $past(fmask_q))
    else $error("fault mask readback wrong");

  a_override_readback: assert property (@(posedge clk) disable iff (!arst_n)
    reg_rd && reg_addr == rail_override_pkg::OVR_ADDR |=> reg_rvalid && reg_rdata == $past(ovr_q))
    else $error("override readback wrong");

  a_rvalid_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    !reg_rd |=> !reg_rvalid)
    else $error("read valid without a read strobe");

  a_b1_permit_off: assert property (@(posedge clk) disable iff (!arst_n)
    !switch_b1_permit |=> !rail_en[3])
    else $error("switch B1 on while not permitted");

  a_a3_permit_off: assert property (@(posedge clk) disable iff (!arst_n)
    !ldo_a3_permit |=> !rail_en[4])
    else $error("LDO A3 on while not permitted");

  a_shared_permit_off: assert property (@(posedge clk) disable iff (!arst_n)
    !shared_rail_permit |=> !rail_en[1] && !rail_en[2])
    else $error("shared rail on while not permitted");

  a_term_forced: assert property (@(posedge clk) disable iff (!arst_n)
    (term_ldo_permit && ovr_q[3]) |=> rail_en[0])
    else $error("termination LDO not forced on");

  a_b1_follow: assert property (@(posedge clk) disable iff (!arst_n)
    (switch_b1_permit && !ovr_q[1]) |=> rail_en[3] == $past(rail_req[2]))
    else $error("switch B1 does not follow its request");

  a_a3_forced: assert property (@(posedge clk) disable iff (!arst_n)
    (ldo_a3_permit && ovr_q[0]) |=> rail_en[4])
    else $error("LDO A3 not forced on");

  a_switch_b2_sel: assert property (@(posedge clk) disable iff (!arst_n)
    shared_sel_ldo |=> !rail_en[1])
    else $error("switch B2 on while LDO A1 selected");

  a_ldo_a1_sel: assert property (@(posedge clk) disable iff (!arst_n)
    !shared_sel_ldo |=> !rail_en[2])
    else $error("LDO A1 on while switch B2 selected");

  a_out4_open_drain: assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 |=> !gp_out_o[3])
    else $error("out 4 driven high");

  a_out3_level: assert property (@(posedge clk) disable iff (!arst_n)
    (out_i2c_mode[2] && out_push_pull[2]) |=> gp_out_oe[2] && gp_out_o[2] == $past(ovr_q[6]))
    else $error("out 3 push-pull level wrong");

  a_out2_open_drain: assert property (@(posedge clk) disable iff (!arst_n)
    (out_i2c_mode[1] && !out_push_pull[1]) |=> !gp_out_o[1] && gp_out_oe[1] == !$past(ovr_q[5]))
    else $error("out 2 open-drain level wrong");

  a_out1_pg_level: assert property (@(posedge clk) disable iff (!arst_n)
    (!out_i2c_mode[0] && out_push_pull[0]) |=> gp_out_oe[0] && gp_out_o[0] == $past(pg_tree[0]))
    else $error("out 1 does not follow its power-good tree");

  a_out4_pg_tree: assert property (@(posedge clk) disable iff (!arst_n)
    !out_i2c_mode[3] |=> gp_out_oe[3] == !$past(pg_tree[3]))
    else $error("out 4 does not follow its power-good tree");

  a_all_masked: assert property (@(posedge clk) disable iff (!arst_n)
    ((rail_fault & ~fmask_q) == 8'h00) |=> !shutdown_req)
    else $error("shutdown without an unmasked fault");

  a_switch_a1_fault: assert property (@(posedge clk) disable iff (!arst_n)
    (rail_fault[6] && !fmask_q[6]) |=> shutdown_req)
    else $error("unmasked switch A1 fault did not shut down");

  a_ldo_a2_fault: assert property (@(posedge clk) disable iff (!arst_n)
    (rail_fault[7] && !fmask_q[7]) |=> shutdown_req)
    else $error("unmasked LDO A2 fault did not shut down");

endmodule

// ===== rail_override_pkg.sv
// Purpose: constants for the rail override / fault mask register pair
// Assumes: byte-wide registers reached by the internal I2C register port
// Notes:   reset values are the factory image of an all-zero part
package rail_override_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] OVR_ADDR   = 8'hA1;
  localparam logic [7:0] FMASK_ADDR = 8'hA2;

  // ==========================================================================
  // reset values
  localparam logic [7:0] OVR_RESET   = 8'h00;
  localparam logic [7:0] FMASK_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ==========================================================================
  // override register fields
  localparam int OUT1_LEVEL_BIT   = 4;   // out1..out4 levels at bits 4..7
  localparam int TERM_LDO_BIT     = 3;
  localparam int SHARED_RAIL_BIT  = 2;
  localparam int SWITCH_B1_BIT    = 1;
  localparam int LDO_A3_BIT       = 0;
  localparam int NUM_GP_OUT       = 4;

  // ==========================================================================
  // fault mask register fields
  localparam int BUCK_RAIL_1_MASK_BIT   = 0;   // buck rails 1..6 at bits 0..5
  localparam int NUM_BUCK         = 6;
  localparam int SWITCH_A1_MASK_BIT = 6;
  localparam int LDO_A2_MASK_BIT  = 7;
  localparam int NUM_FAULT        = 8;

  // ==========================================================================
  // rail enable output order
  localparam int EN_TERM_LDO      = 0;
  localparam int EN_SWITCH_B2     = 1;
  localparam int EN_LDO_A1        = 2;
  localparam int EN_SWITCH_B1     = 3;
  localparam int EN_LDO_A3        = 4;
  localparam int NUM_EN           = 5;

endpackage

// ===== reg_host.sv
// Purpose: host model that reaches the override and fault mask registers
// Assumes: one-cycle strobes; read answer stands in the cycle after the strobe
// Notes:   released lines show the inverse of the last value, never a stale copy
module reg_host (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end
  // ==========================================================================
  // single-byte write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(posedge clk) #1;
    {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask
  // single-byte read, data taken in the cycle it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk) #1;
    {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge clk) #1;
    {reg_addr, reg_rd} = {~a, 1'b0};
    {d, ok} = {reg_rdata, reg_rvalid};
  endtask
endmodule

// ===== testbench.sv
// Purpose: self-checking bench for the rail override and fault mask registers
// Assumes: outputs follow inputs one edge later, register writes two edges later
// Notes:   loops sweep bit patterns so every field is seen in both states
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t mismatch got %h exp %h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, arst_n, reg_wr, reg_rd, reg_rvalid, shared_sel_ldo, shutdown_req;
  logic       term_ldo_permit, shared_rail_permit, switch_b1_permit, ldo_a3_permit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rail_fault;
  logic [3:0] out_i2c_mode, out_push_pull, rail_req, pg_tree, gp_out_o, gp_out_oe;
  logic [4:0] rail_en;
  int         bad_count, n_tests;

  reg_host host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid);
  rail_override_regs uut (.clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .reg_rvalid, .out_i2c_mode, .out_push_pull, .shared_sel_ldo,
    .term_ldo_permit, .shared_rail_permit, .switch_b1_permit, .ldo_a3_permit,
    .rail_req, .pg_tree, .rail_fault, .rail_en, .gp_out_o, .gp_out_oe, .shutdown_req);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================================
  // helpers
  task automatic stop_test;
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // two edges cover the register-to-output path
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host.rd(a, d, ok);
    `CHK({ok, d}, {1'b1, e})
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs;
    chk_rd(rail_override_pkg::OVR_ADDR, rail_override_pkg::OVR_RESET);
    chk_rd(rail_override_pkg::FMASK_ADDR, rail_override_pkg::FMASK_RESET);
    host.wr(8'hA7, 8'h5A);
    chk_rd(8'hA7, 8'h00);
    host.wr(rail_override_pkg::OVR_ADDR, 8'hC3);
    chk_rd(rail_override_pkg::OVR_ADDR, 8'hC3);
    host.wr(rail_override_pkg::FMASK_ADDR, 8'h3C);
    chk_rd(rail_override_pkg::FMASK_ADDR, 8'h3C);
  endtask
  task automatic t_rails;
    logic [7:0] kk;
    logic [3:0] o, p, e;
    for (int k = 0; k < 256; k++) begin
      kk = k[7:0];
      {p, o} = kk;
      rail_req = kk[5:2] ^ kk[7:4];
      shared_sel_ldo = kk[0] ^ kk[7];
      {ldo_a3_permit, switch_b1_permit, shared_rail_permit, term_ldo_permit} = p;
      host.wr(rail_override_pkg::OVR_ADDR, {4'h0, o[0], o[1], o[2], o[3]});
      settle;
      e = p & (o | rail_req);
      `CHK(rail_en, {e[3:2], shared_sel_ldo & e[1], ~shared_sel_ldo & e[1], e[0]})
    end
  endtask
  task automatic t_gpout;
    logic [7:0] kk;
    logic [3:0] lvl, v, pp, oe;
    for (int k = 0; k < 256; k++) begin
      kk = k[7:0];
      {out_push_pull, out_i2c_mode} = kk;
      pg_tree = kk[5:2];
      lvl = ~kk[3:0] ^ kk[7:4];
      host.wr(rail_override_pkg::OVR_ADDR, {lvl, 4'h0});
      settle;
      v = (kk[3:0] & lvl) | (~kk[3:0] & pg_tree);
      pp = {1'b0, kk[6:4]};
      oe = pp | ~v;
      `CHK(gp_out_oe, oe)
      `CHK(gp_out_o & oe, pp & v)
    end
  endtask
  task automatic t_fault;
    for (int i = 0; i < 8; i++) begin
      rail_fault = 8'h01 << i;
      host.wr(rail_override_pkg::FMASK_ADDR, 8'h01 << i);
      settle;
      `CHK(shutdown_req, 1'b0)
      host.wr(rail_override_pkg::FMASK_ADDR, ~(8'h01 << i));
      settle;
      `CHK(shutdown_req, 1'b1)
    end
    rail_fault = 8'hC0;
    host.wr(rail_override_pkg::FMASK_ADDR, 8'hC0);
    settle;
    `CHK(shutdown_req, 1'b0)
    rail_fault = 8'h00;
    settle;
    `CHK(shutdown_req, 1'b0)
  endtask
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    {bad_count, n_tests, arst_n, shared_sel_ldo} = '0;
    {term_ldo_permit, shared_rail_permit, switch_b1_permit, ldo_a3_permit} = 4'hF;
    {out_i2c_mode, out_push_pull, rail_req, pg_tree} = 16'hFFFF;
    rail_fault = 8'hFF;
    repeat (10) @(posedge clk);
    #1;
    `CHK({rail_en, gp_out_oe, shutdown_req}, 10'h000)
    arst_n = 1'b1;
    rail_fault = 8'h00;
    t_regs;
    t_rails;
    t_gpout;
    t_fault;
    stop_test;
  end
  // the sweeps need about 2150 cycles; a hang is cut well past that
  initial begin
    #100000;
    bad_count++;
    stop_test;
  end
endmodule
